// [hdl/pbm_port_b.sv]
// Function
// - pull-up override enable selects override value only
// - otherwise pull-up on when dir,out,off equal 010
// - driver enable from override value or direction bit
// - driven value from override or output bit
// - toggle override inverts the output bit
// - input enable override beats run/sleep state
// - raw input tapped before synchroniser, consumers synchronise
// - strobes per port, clock/sleep/pull-off shared
// - override pairs come from the owning peripheral
// - every port B bit is a pin-change source
// - SPI slave forces select pin to input
// - slave SPI overrides apply whatever the select pin level
// - forced-input SPI pins keep pull-up via output bit
// - SPI slave forces clock pin to input
// - SPI master forces master-in pin to input
// - SPI slave forces master-out pin to input
// - bits 2,1,0 carry timer clock, output, capture
// - direction one means output, zero input
// - sleep clamps inputs unless override keeps them
`timescale 1ns/1ns
module pbm_port_b
  import pbm_pkg::*;
#(
  parameter int WIDTH = PBM_WIDTH
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_dir_wr_en,
  input wire logic [WIDTH-1:0] i_dir_wr_data,
  input wire logic i_out_wr_en,
  input wire logic [WIDTH-1:0] i_out_wr_data,
  input wire logic i_toggle_wr_en,
  input wire logic [WIDTH-1:0] i_toggle_wr_data,
  input wire logic i_global_pullup_off,
  input wire logic i_sleep,
  input wire logic [WIDTH-1:0] i_toggle_override_en,
  input wire logic i_spi_en,
  input wire logic i_spi_master,
  input wire logic i_spi_sck_out,
  input wire logic i_spi_slave_out,
  input wire logic i_spi_master_out,
  input wire logic i_timer3_out_en,
  input wire logic i_timer3_mod_output,
  input wire logic i_pin_change_group_en,
  input wire logic [WIDTH-1:0] i_pin_change_mask,
  input wire logic [WIDTH-1:0] i_pad_in,
  output logic [WIDTH-1:0] o_pad_out,
  output logic [WIDTH-1:0] o_pad_oe_n,
  output logic [WIDTH-1:0] o_pad_pullup,
  output logic [WIDTH-1:0] o_pin_dir_bit,
  output logic [WIDTH-1:0] o_pin_out_bit,
  output logic [WIDTH-1:0] o_pin_state,
  output logic [WIDTH-1:0] o_pin_change_src,
  output logic o_spi_ss_in,
  output logic o_spi_sck_in,
  output logic o_spi_master_in,
  output logic o_spi_slave_in,
  output logic o_timer_ext_clock_in,
  output logic o_timer3_capture_in
);

  // direction and output bits of the port
  logic [WIDTH-1:0] dir_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  // override pairs per pin, as the peripherals would present them
  logic [WIDTH-1:0] pull_override_en;
  logic [WIDTH-1:0] pull_override_val;
  logic [WIDTH-1:0] dir_override_en;
  logic [WIDTH-1:0] dir_override_val;
  logic [WIDTH-1:0] value_override_en;
  logic [WIDTH-1:0] value_override_val;
  logic [WIDTH-1:0] input_en_override_en;
  logic [WIDTH-1:0] input_en_override_val;

  // resolved pad controls from the pin cells
  logic [WIDTH-1:0] pullup_c;
  logic [WIDTH-1:0] drive_en_c;
  logic [WIDTH-1:0] drive_val_c;
  logic [WIDTH-1:0] input_en_c;
  logic [WIDTH-1:0] alt_raw_input;

  // spi role decode
  logic spi_slave;
  logic spi_master;

  assign spi_slave = i_spi_en & !i_spi_master;
  assign spi_master = i_spi_en & i_spi_master;

  // direction bits: one write strobe serves the whole port
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_reg <= PBM_DIR_RESET;
    end else if (i_dir_wr_en) begin
      dir_reg <= i_dir_wr_data;
    end
  end

  // output bits: write, then software toggle, then per-pin toggle override
  always_comb begin
    out_next = i_out_wr_en ? i_out_wr_data : out_reg;
    if (i_toggle_wr_en) begin
      out_next = out_next ^ i_toggle_wr_data;
    end
    out_next = out_next ^ i_toggle_override_en;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_reg <= PBM_OUT_RESET;
    end else begin
      out_reg <= out_next;
    end
  end

  // override pairs for port B; these are the terms the spi and timer own
  always_comb begin
    pull_override_en = '0;
    pull_override_val = '0;
    dir_override_en = '0;
    dir_override_val = '0;
    value_override_en = '0;
    value_override_val = '0;
    // select pin: slave forces input, pull-up still follows its output bit
    pull_override_en[PBM_BIT_SS] = spi_slave;
    pull_override_val[PBM_BIT_SS] = out_reg[PBM_BIT_SS] & !i_global_pullup_off;
    dir_override_en[PBM_BIT_SS] = spi_slave;
    // clock pin: slave input, master drives the spi clock when dir is one
    pull_override_en[PBM_BIT_SCK] = spi_slave;
    pull_override_val[PBM_BIT_SCK] = out_reg[PBM_BIT_SCK] & !i_global_pullup_off;
    dir_override_en[PBM_BIT_SCK] = spi_slave;
    value_override_en[PBM_BIT_SCK] = spi_master;
    value_override_val[PBM_BIT_SCK] = i_spi_sck_out;
    // master-in pin: master input, slave drives its data out
    pull_override_en[PBM_BIT_MISO] = spi_master;
    pull_override_val[PBM_BIT_MISO] = out_reg[PBM_BIT_MISO] & !i_global_pullup_off;
    dir_override_en[PBM_BIT_MISO] = spi_master;
    value_override_en[PBM_BIT_MISO] = spi_slave;
    value_override_val[PBM_BIT_MISO] = i_spi_slave_out;
    // master-out pin: slave input, master drives its data out
    pull_override_en[PBM_BIT_MOSI] = spi_slave;
    pull_override_val[PBM_BIT_MOSI] = out_reg[PBM_BIT_MOSI] & !i_global_pullup_off;
    dir_override_en[PBM_BIT_MOSI] = spi_slave;
    value_override_en[PBM_BIT_MOSI] = spi_master;
    value_override_val[PBM_BIT_MOSI] = i_spi_master_out;
    // timer3 modulator output, only seen when the direction bit is one
    value_override_en[PBM_BIT_T3OUT] = i_timer3_out_en;
    value_override_val[PBM_BIT_T3OUT] = i_timer3_mod_output;
  end

  // an enabled pin-change source keeps its input buffer awake in sleep
  assign input_en_override_en = i_pin_change_mask & {WIDTH{i_pin_change_group_en}};
  assign input_en_override_val = '1;

  // one resolver per pin; shared signals fan out, the rest are per pin
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      pbm_pin_cell u_cell (
        .i_pin_dir_bit(dir_reg[g]),
        .i_pin_out_bit(out_reg[g]),
        .i_global_pullup_off(i_global_pullup_off),
        .i_sleep(i_sleep),
        .i_pull_override_en(pull_override_en[g]),
        .i_pull_override_val(pull_override_val[g]),
        .i_dir_override_en(dir_override_en[g]),
        .i_dir_override_val(dir_override_val[g]),
        .i_value_override_en(value_override_en[g]),
        .i_value_override_val(value_override_val[g]),
        .i_input_en_override_en(input_en_override_en[g]),
        .i_input_en_override_val(input_en_override_val[g]),
        .i_pad_in(i_pad_in[g]),
        .o_pullup(pullup_c[g]),
        .o_drive_en(drive_en_c[g]),
        .o_drive_val(drive_val_c[g]),
        .o_input_en(input_en_c[g]),
        .o_alt_raw_input(alt_raw_input[g])
      );
    end
  endgenerate

  // pad drive registered; reset leaves every pad tri-stated with no pull-up
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pad_out <= '0;
      o_pad_oe_n <= '1;
      o_pad_pullup <= '0;
    end else begin
      o_pad_out <= drive_val_c;
      o_pad_oe_n <= ~drive_en_c;
      o_pad_pullup <= pullup_c & ~drive_en_c;
    end
  end

  // readback copies of the control bits
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_dir_bit <= PBM_DIR_RESET;
      o_pin_out_bit <= PBM_OUT_RESET;
    end else begin
      o_pin_dir_bit <= dir_reg;
      o_pin_out_bit <= out_reg;
    end
  end

  // port read path: clamped pad level through two flops, costs two cycles
  pbm_sync2 #(
    .WIDTH(WIDTH)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_async(alt_raw_input),
    .o_sync(o_pin_state)
  );

  // raw taps stay unregistered: a flop here would clock an async level, and
  // the timer clock input must keep its edges; every consumer synchronises
  assign o_pin_change_src = alt_raw_input;
  assign o_spi_ss_in = alt_raw_input[PBM_BIT_SS];
  assign o_spi_sck_in = alt_raw_input[PBM_BIT_SCK];
  assign o_spi_master_in = alt_raw_input[PBM_BIT_MISO];
  assign o_spi_slave_in = alt_raw_input[PBM_BIT_MOSI];
  assign o_timer_ext_clock_in = alt_raw_input[PBM_BIT_TCLK];
  assign o_timer3_capture_in = alt_raw_input[PBM_BIT_T3CAP];

  // pull-up on a forced-input select pin follows its output bit
  property p_ss_pull_forced;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    spi_slave |=> (o_pad_pullup[PBM_BIT_SS] ==
                   ($past(out_reg[PBM_BIT_SS]) && !$past(i_global_pullup_off)));
  endproperty
  a_ss_pull_forced: assert property (p_ss_pull_forced)
    else $error("select pin pull-up ignores its output bit");

  // plain pull-up decode without any override
  property p_plain_pull;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    1'b1 |=> (o_pad_pullup[PBM_BIT_PLAIN] ==
              (!$past(dir_reg[PBM_BIT_PLAIN]) && $past(out_reg[PBM_BIT_PLAIN])
               && !$past(i_global_pullup_off)));
  endproperty
  a_plain_pull: assert property (p_plain_pull)
    else $error("plain pin pull-up decode wrong");

  // slave mode forces select pin to input whatever its direction bit
  property p_ss_input;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    spi_slave |=> o_pad_oe_n[PBM_BIT_SS];
  endproperty
  a_ss_input: assert property (p_ss_input)
    else $error("select pin driven in slave mode");

  // clock pin: input in slave mode, direction bit in master mode
  property p_sck_dir;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    spi_master |=> (o_pad_oe_n[PBM_BIT_SCK] == !$past(dir_reg[PBM_BIT_SCK]))
                   && (o_pad_out[PBM_BIT_SCK] == $past(i_spi_sck_out));
  endproperty
  a_sck_dir: assert property (p_sck_dir)
    else $error("master clock pin direction or value wrong");

  property p_sck_slave;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    spi_slave |=> o_pad_oe_n[PBM_BIT_SCK];
  endproperty
  a_sck_slave: assert property (p_sck_slave)
    else $error("clock pin driven in slave mode");

  // master-in pin forced to input as master
  property p_miso_master;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    spi_master |=> o_pad_oe_n[PBM_BIT_MISO];
  endproperty
  a_miso_master: assert property (p_miso_master)
    else $error("master-in pin driven in master mode");

  // master-out pin forced to input as slave
  property p_mosi_slave;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    spi_slave |=> o_pad_oe_n[PBM_BIT_MOSI];
  endproperty
  a_mosi_slave: assert property (p_mosi_slave)
    else $error("master-out pin driven in slave mode");

  // toggle override flips the output bit when no write competes
  property p_toggle;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (!i_out_wr_en && !i_toggle_wr_en) |=>
      (out_reg == ($past(out_reg) ^ $past(i_toggle_override_en)));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle override did not invert output bit");

  // sleeping pin without override reads low after the synchroniser
  property p_sleep_clamp;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_sleep && !input_en_override_en[PBM_BIT_PLAIN]) [*3] |-> !o_pin_state[PBM_BIT_PLAIN];
  endproperty
  a_sleep_clamp: assert property (p_sleep_clamp)
    else $error("sleeping input not clamped");

  // timer3 modulator output reaches an output pin
  property p_t3_out;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_timer3_out_en && dir_reg[PBM_BIT_T3OUT]) |=>
      (!o_pad_oe_n[PBM_BIT_T3OUT] && (o_pad_out[PBM_BIT_T3OUT] == $past(i_timer3_mod_output)));
  endproperty
  a_t3_out: assert property (p_t3_out)
    else $error("timer3 output not on its pin");

  // a driven select pad shows no pull-up, and drives only on its own bits outside slave mode
  property p_no_pull_driven;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_pad_oe_n[PBM_BIT_SS] |->
      (!o_pad_pullup[PBM_BIT_SS] && $past(dir_reg[PBM_BIT_SS]) && !$past(spi_slave));
  endproperty
  a_no_pull_driven: assert property (p_no_pull_driven)
    else $error("select pad driven or pulled against its controls");

  // plain pin: direction bit picks the driver, output bit the value
  property p_plain_drive;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    1'b1 |=> (o_pad_oe_n[PBM_BIT_PLAIN] == !$past(dir_reg[PBM_BIT_PLAIN]))
             && (o_pad_out[PBM_BIT_PLAIN] == $past(out_reg[PBM_BIT_PLAIN]));
  endproperty
  a_plain_drive: assert property (p_plain_drive)
    else $error("plain pin drive does not follow its bits");

  // master-in pin as slave: direction bit decides, slave data drives it
  property p_miso_slave;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    spi_slave |=> (o_pad_oe_n[PBM_BIT_MISO] == !$past(dir_reg[PBM_BIT_MISO]))
                  && (o_pad_out[PBM_BIT_MISO] == $past(i_spi_slave_out));
  endproperty
  a_miso_slave: assert property (p_miso_slave)
    else $error("slave data pin direction or value wrong");

  // master-out pin as master: direction bit decides, master data drives it
  property p_mosi_master;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    spi_master |=> (o_pad_oe_n[PBM_BIT_MOSI] == !$past(dir_reg[PBM_BIT_MOSI]))
                   && (o_pad_out[PBM_BIT_MOSI] == $past(i_spi_master_out));
  endproperty
  a_mosi_master: assert property (p_mosi_master)
    else $error("master data pin direction or value wrong");

  // port read path lags the raw tap by exactly the two synchroniser flops
  property p_pin_sync;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    1'b1 |-> ##2 (o_pin_state == $past(alt_raw_input, 2));
  endproperty
  a_pin_sync: assert property (p_pin_sync)
    else $error("pin read path delay wrong");

endmodule : pbm_port_b

// [hdl/pbm_pkg.sv]
// shared constants for the port B pin override mux
package pbm_pkg;

  // port geometry
  localparam int PBM_WIDTH = 8;

  // reset values of the direction and output bits: all pins tri-stated
  localparam logic [7:0] PBM_DIR_RESET = 8'h00;
  localparam logic [7:0] PBM_OUT_RESET = 8'h00;

  // {dir, out, global pull-up off} code that switches the pull-up on
  localparam logic [2:0] PBM_PU_ON_CODE = 3'h2;

  // pin positions of the alternate functions on port B
  localparam int PBM_BIT_SS = 7;
  localparam int PBM_BIT_PLAIN = 6;
  localparam int PBM_BIT_SCK = 5;
  localparam int PBM_BIT_MISO = 4;
  localparam int PBM_BIT_MOSI = 3;
  localparam int PBM_BIT_TCLK = 2;
  localparam int PBM_BIT_T3OUT = 1;
  localparam int PBM_BIT_T3CAP = 0;

  // depth of the pin read synchroniser
  localparam int PBM_SYNC_STAGES = 2;

endpackage : pbm_pkg

// [hdl/pbm_sync2.sv]
`timescale 1ns/1ns
// two flip-flop synchroniser, one per bit; the first stage feeds only the second
module pbm_sync2 #(
  parameter int WIDTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;

  // metastability stage, read by nothing but the second stage
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule : pbm_sync2

// [hdl/pbm_pin_cell.sv]
`timescale 1ns/1ns
// resolves the override pairs of one pin into pad controls
module pbm_pin_cell
  import pbm_pkg::*;
(
  input wire logic i_pin_dir_bit,
  input wire logic i_pin_out_bit,
  input wire logic i_global_pullup_off,
  input wire logic i_sleep,
  input wire logic i_pull_override_en,
  input wire logic i_pull_override_val,
  input wire logic i_dir_override_en,
  input wire logic i_dir_override_val,
  input wire logic i_value_override_en,
  input wire logic i_value_override_val,
  input wire logic i_input_en_override_en,
  input wire logic i_input_en_override_val,
  input wire logic i_pad_in,
  output logic o_pullup,
  output logic o_drive_en,
  output logic o_drive_val,
  output logic o_input_en,
  output logic o_alt_raw_input
);

  // pull-up: override wins outright, else only the input-with-one case
  always_comb begin
    if (i_pull_override_en) begin
      o_pullup = i_pull_override_val;
    end else begin
      o_pullup = ({i_pin_dir_bit, i_pin_out_bit, i_global_pullup_off} == PBM_PU_ON_CODE);
    end
  end

  // driver enable: a one in the direction bit means output
  assign o_drive_en = i_dir_override_en ? i_dir_override_val : i_pin_dir_bit;

  // driven value; meaningless while the driver is off
  assign o_drive_val = i_value_override_en ? i_value_override_val : i_pin_out_bit;

  // input enable follows the power state unless a peripheral keeps it alive
  assign o_input_en = i_input_en_override_en ? i_input_en_override_val : !i_sleep;

  // clamp low at the buffer, so a floating pad costs no current in sleep
  assign o_alt_raw_input = i_pad_in & o_input_en;

endmodule : pbm_pin_cell

// [bench/pbm_pad_model.sv]
`timescale 1ns/1ns
// outside world of the pins: design drive wins, then a board driver, then the pull-up
module pbm_pad_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_pad_out,
  input wire logic [7:0] i_pad_oe_n,
  input wire logic [7:0] i_pad_pullup,
  input wire logic [7:0] i_ext_en,
  input wire logic [7:0] i_ext_val,
  output logic [7:0] o_pad_in
);
  logic [7:0] float_reg = 8'h55;

  // an undriven pin wanders every cycle, so a stale level never passes for a real one
  always_ff @(posedge i_sys_clk) begin
    float_reg <= ~float_reg;
  end

  // resolve each wire from all parties; the bench never drives against the design
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!i_pad_oe_n[i]) o_pad_in[i] = i_pad_out[i];
      else if (i_ext_en[i]) o_pad_in[i] = i_ext_val[i];
      else if (i_pad_pullup[i]) o_pad_in[i] = 1'b1;
      else o_pad_in[i] = float_reg[i];
    end
  end
endmodule : pbm_pad_model

// [bench/port_pin_override_mux_tb_top.sv]
`timescale 1ns/1ns
module port_pin_override_mux_tb_top;
  import pbm_pkg::*;
  logic i_sys_clk, i_rst_n, i_dir_wr_en, i_out_wr_en, i_toggle_wr_en;
  logic [7:0] i_dir_wr_data, i_out_wr_data, i_toggle_wr_data, i_toggle_override_en;
  logic i_global_pullup_off, i_sleep, i_spi_en, i_spi_master, i_spi_sck_out;
  logic i_spi_slave_out, i_spi_master_out, i_timer3_out_en, i_timer3_mod_output;
  logic i_pin_change_group_en;
  logic [7:0] i_pin_change_mask, i_pad_in, ext_en, ext_val;
  logic [7:0] o_pad_out, o_pad_oe_n, o_pad_pullup, o_pin_dir_bit, o_pin_out_bit;
  logic [7:0] o_pin_state, o_pin_change_src;
  logic o_spi_ss_in, o_spi_sck_in, o_spi_master_in, o_spi_slave_in;
  logic o_timer_ext_clock_in, o_timer3_capture_in;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;

  pbm_port_b #(.WIDTH(8)) dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_dir_wr_en(i_dir_wr_en), .i_dir_wr_data(i_dir_wr_data), .i_out_wr_en(i_out_wr_en),
    .i_out_wr_data(i_out_wr_data), .i_toggle_wr_en(i_toggle_wr_en),
    .i_toggle_wr_data(i_toggle_wr_data), .i_global_pullup_off(i_global_pullup_off),
    .i_sleep(i_sleep), .i_toggle_override_en(i_toggle_override_en), .i_spi_en(i_spi_en),
    .i_spi_master(i_spi_master), .i_spi_sck_out(i_spi_sck_out),
    .i_spi_slave_out(i_spi_slave_out), .i_spi_master_out(i_spi_master_out),
    .i_timer3_out_en(i_timer3_out_en), .i_timer3_mod_output(i_timer3_mod_output),
    .i_pin_change_group_en(i_pin_change_group_en), .i_pin_change_mask(i_pin_change_mask),
    .i_pad_in(i_pad_in), .o_pad_out(o_pad_out), .o_pad_oe_n(o_pad_oe_n),
    .o_pad_pullup(o_pad_pullup), .o_pin_dir_bit(o_pin_dir_bit),
    .o_pin_out_bit(o_pin_out_bit), .o_pin_state(o_pin_state),
    .o_pin_change_src(o_pin_change_src), .o_spi_ss_in(o_spi_ss_in),
    .o_spi_sck_in(o_spi_sck_in), .o_spi_master_in(o_spi_master_in),
    .o_spi_slave_in(o_spi_slave_in), .o_timer_ext_clock_in(o_timer_ext_clock_in),
    .o_timer3_capture_in(o_timer3_capture_in));

  pbm_pad_model pads (.i_sys_clk(i_sys_clk), .i_pad_out(o_pad_out),
    .i_pad_oe_n(o_pad_oe_n), .i_pad_pullup(o_pad_pullup), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_pad_in(i_pad_in));

  // 100 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // a hang is cut short well beyond the 56 or so cycles the tests need
  initial begin
    forever begin
      @(posedge i_sys_clk);
      cycles++;
      if (cycles == 2000) begin
        n_fail++;
        print_verdict();
      end
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : step

  // one-cycle strobe: 0 direction, 1 output, 2 toggle
  task automatic wr(input int k, input logic [7:0] d);
    i_dir_wr_en = (k == 0);
    i_out_wr_en = (k == 1);
    i_toggle_wr_en = (k == 2);
    i_dir_wr_data = d;
    i_out_wr_data = d;
    i_toggle_wr_data = d;
    step(1);
    i_dir_wr_en = 1'b0;
    i_out_wr_en = 1'b0;
    i_toggle_wr_en = 1'b0;
  endtask : wr

  task automatic t_gpio();
    wr(0, 8'h0F);
    wr(1, 8'h35);
    step(2);
    check("oe_n", o_pad_oe_n, 8'hF0);
    check("pad_out", o_pad_out & 8'h0F, 8'h05);
    check("pullup", o_pad_pullup, 8'h30);
    check("dir_bit", o_pin_dir_bit, 8'h0F);
    i_global_pullup_off = 1'b1;
    step(2);
    check("pullup_off", o_pad_pullup, 8'h00);
    wr(2, 8'h0F);
    step(2);
    check("out_bit_tog", o_pin_out_bit, 8'h3A);
    i_toggle_override_en = 8'h04;
    step(1);
    i_toggle_override_en = 8'h00;
    step(2);
    check("out_bit_ovr", o_pin_out_bit, 8'h3E);
    check("pad_out_ovr", o_pad_out & 8'h0F, 8'h0E);
    i_global_pullup_off = 1'b0;
    $display("test gpio done");
  endtask : t_gpio

  task automatic t_spi_slave();
    wr(0, 8'hFF);
    wr(1, 8'hFF);
    i_spi_en = 1'b1;
    i_spi_slave_out = 1'b1;
    ext_en = 8'h80;
    ext_val = 8'h00;
    step(2);
    check("oe_n", o_pad_oe_n, 8'hA8);
    check("pullup", o_pad_pullup, 8'hA8);
    check("miso_out", {7'h00, o_pad_out[4]}, 8'h01);
    check("ss_low", {7'h00, o_spi_ss_in}, 8'h00);
    i_spi_slave_out = 1'b0;
    wr(1, 8'h80);
    step(2);
    check("miso_out0", {7'h00, o_pad_out[4]}, 8'h00);
    check("pullup_own", o_pad_pullup, 8'h80);
    i_global_pullup_off = 1'b1;
    step(2);
    check("pullup_off", o_pad_pullup, 8'h00);
    i_global_pullup_off = 1'b0;
    ext_en = 8'h00;
    $display("test spi slave done");
  endtask : t_spi_slave

  task automatic t_spi_master();
    i_spi_master = 1'b1;
    i_spi_sck_out = 1'b1;
    i_spi_master_out = 1'b0;
    wr(1, 8'h10);
    step(2);
    check("oe_n", o_pad_oe_n, 8'h10);
    check("sck_mosi", o_pad_out & 8'h28, 8'h20);
    check("pullup", o_pad_pullup, 8'h10);
    i_spi_sck_out = 1'b0;
    i_spi_master_out = 1'b1;
    wr(0, 8'h00);
    step(2);
    check("oe_n_dir", o_pad_oe_n, 8'hFF);
    wr(0, 8'h28);
    step(2);
    check("sck_mosi2", o_pad_out & 8'h28, 8'h08);
    i_spi_en = 1'b0;
    i_spi_master = 1'b0;
    $display("test spi master done");
  endtask : t_spi_master

  task automatic t_timer3();
    wr(0, 8'h02);
    i_timer3_out_en = 1'b1;
    i_timer3_mod_output = 1'b1;
    step(2);
    check("t3_hi", {7'h00, o_pad_out[1]}, 8'h01);
    i_timer3_mod_output = 1'b0;
    step(2);
    check("t3_lo", {7'h00, o_pad_out[1]}, 8'h00);
    i_timer3_out_en = 1'b0;
    i_timer3_mod_output = 1'b1;
    wr(1, 8'h02);
    step(2);
    check("t3_off", o_pad_oe_n, 8'hFD);
    i_timer3_mod_output = 1'b0;
    step(2);
    check("t3_off_val", {7'h00, o_pad_out[1]}, 8'h01);
    $display("test timer3 done");
  endtask : t_timer3

  task automatic t_inputs();
    wr(0, 8'h00);
    wr(1, 8'h00);
    step(1);
    ext_en = 8'hFF;
    ext_val = 8'hA5;
    #1;
    check("raw", o_pin_change_src, 8'hA5);
    check("taps", {2'b00, o_spi_ss_in, o_spi_sck_in, o_spi_master_in, o_spi_slave_in,
      o_timer_ext_clock_in, o_timer3_capture_in}, 8'h33);
    step(3);
    check("pin_state", o_pin_state, 8'hA5);
    i_sleep = 1'b1;
    #1;
    check("clamp", o_pin_change_src, 8'h00);
    step(1);
    i_pin_change_group_en = 1'b1;
    i_pin_change_mask = 8'h0F;
    #1;
    check("kept", o_pin_change_src, 8'h05);
    step(3);
    check("pin_state_slp", o_pin_state, 8'h05);
    i_sleep = 1'b0;
    $display("test inputs done");
  endtask : t_inputs

  initial begin
    {i_dir_wr_en, i_out_wr_en, i_toggle_wr_en} = 3'h0;
    {i_dir_wr_data, i_out_wr_data, i_toggle_wr_data, i_toggle_override_en} = 32'h0;
    {i_global_pullup_off, i_sleep, i_spi_en, i_spi_master, i_spi_sck_out} = 5'h00;
    {i_spi_slave_out, i_spi_master_out, i_timer3_out_en, i_timer3_mod_output} = 4'h0;
    i_pin_change_group_en = 1'b0;
    i_pin_change_mask = 8'h00;
    ext_en = 8'h00;
    ext_val = 8'h00;
    i_rst_n = 1'b0;
    step(5);
    check("rst_oe_n", o_pad_oe_n, 8'hFF);
    check("rst_pullup", o_pad_pullup, 8'h00);
    check("rst_dir", o_pin_dir_bit, PBM_DIR_RESET);
    i_rst_n = 1'b1;
    step(1);
    t_gpio();
    t_spi_slave();
    t_spi_master();
    t_timer3();
    t_inputs();
    print_verdict();
  end
endmodule : port_pin_override_mux_tb_top
